// *** fspm_self_prog_map.sv ***
// Function
// - erase, write, lock timed 3.7 to 4.5 ms
// - boot size from two fuse bits
// - boot start per size, ends at fff
// - readable region below c00, other above
// - twelve-bit program word address
// - 32-word pages, word from pointer 5:1
// - page from pointer bits 12:6
// - pointer bits 15:13 ignored
// - pointer bit 0 is read byte select
// - only nonreadable region read while busy
// - store within four cycles of control write
// - busy flag held until reenable executed
//
// Purpose: self-programming sequencer and address map
// Assumes: one cpu clock, timer counts at the reference clock
// Notes:   timing uses the midpoint of the allowed window
`timescale 1ns/100ps
module fspm_self_prog_map #(
  parameter int PROG_CYC = 82000
) (
  input  wire logic                ref_clk,
  input  wire logic                rst_b,
  input  fspm_pkg::fspm_cpu_s      cpu,
  input  wire logic                eepromWriteActiveFlag,
  input  wire logic [1:0]          bootSize,
  input  wire logic [11:0]         fetchAddr,
  output fspm_pkg::fspm_flash_s    flash,
  output fspm_pkg::fspm_map_s      bootMap,
  output logic [7:0]               selfProgControlReg,
  output logic                     readRegionBusyFlag,
  output logic                     fetchBlocked,
  output logic                     readByteSel
);
  import fspm_pkg::*;

  typedef struct packed {
    fspm_state_e       st;
    logic [7:0]        ctrl;
    logic [2:0]        win;
    logic [16:0]       timer;
    logic              busy;
    logic              blocked;
    logic              fetchBlk;
    logic              byteSel;
    fspm_flash_s       fl;
    fspm_map_s         mp;
  } fspm_reg_s;

  fspm_reg_s state_ff;
  fspm_reg_s nxt_state;
  fspm_map_s mapComb;

  fspm_boot_map u_boot_map (
    .bootSize (bootSize),
    .map      (mapComb)
  );

  // ==========================================================================
  // sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_state.fl.bufWrite  = 1'b0;
    nxt_state.fl.pageErase = 1'b0;
    nxt_state.fl.pageWrite = 1'b0;
    nxt_state.fl.lockWrite = 1'b0;
    nxt_state.fl.bufClear  = 1'b0;
    nxt_state.mp = mapComb;
    nxt_state.byteSel = cpu.zPtr[0];
    nxt_state.fl.bufWord = cpu.zPtr[Z_WORD_MSB:Z_WORD_LSB];
    nxt_state.fl.pageSel = cpu.zPtr[Z_PAGE_MSB:Z_PAGE_LSB];
    case (state_ff.st)
      FS_IDLE: begin
        // eeprom write locks out the control register entirely
        if (cpu.ctrlWrite && !eepromWriteActiveFlag && cpu.ctrlData[0]) begin
          nxt_state.ctrl = cpu.ctrlData;
          nxt_state.win  = SPM_WINDOW;
          nxt_state.st   = FS_ARMED;
        end
      end
      FS_ARMED: begin
        if (cpu.spmExec) begin
          if (state_ff.ctrl == CMD_FILL) begin
            nxt_state.fl.bufWrite = 1'b1;
            nxt_state.ctrl = 8'h00;
            nxt_state.st   = FS_IDLE;
          end else if (state_ff.ctrl[6:0] == CMD_REEN_LO) begin
            nxt_state.blocked = 1'b0;
            nxt_state.busy = 1'b0;
            nxt_state.fl.bufClear = 1'b1;
            nxt_state.ctrl = 8'h00;
            nxt_state.st   = FS_IDLE;
          end else if (state_ff.ctrl[6:0] == CMD_ERASE_LO ||
                       state_ff.ctrl[6:0] == CMD_WRITE_LO ||
                       state_ff.ctrl[6:0] == CMD_LOCK_LO) begin
            nxt_state.fl.pageErase = (state_ff.ctrl[6:0] == CMD_ERASE_LO);
            nxt_state.fl.pageWrite = (state_ff.ctrl[6:0] == CMD_WRITE_LO);
            nxt_state.fl.lockWrite = (state_ff.ctrl[6:0] == CMD_LOCK_LO);
            if (state_ff.ctrl[6:0] != CMD_LOCK_LO) begin
              nxt_state.blocked = 1'b1;
              nxt_state.busy = 1'b1;
            end
            nxt_state.timer = 17'(PROG_CYC);
            nxt_state.st    = FS_BUSY;
          end else begin
            nxt_state.ctrl = 8'h00;
            nxt_state.st   = FS_IDLE;
          end
        end else if (state_ff.win == 3'h1) begin
          nxt_state.ctrl = 8'h00;
          nxt_state.st   = FS_IDLE;
        end else begin
          nxt_state.win = state_ff.win - 3'h1;
        end
      end
      FS_BUSY: begin
        if (state_ff.timer == 17'h00001) begin
          // page write empties the temporary buffer on completion
          nxt_state.fl.bufClear = state_ff.ctrl[6:0] == CMD_WRITE_LO;
          nxt_state.ctrl = 8'h00;
          nxt_state.st   = FS_IDLE;
        end else begin
          nxt_state.timer = state_ff.timer - 17'h00001;
        end
      end
      default: nxt_state.st = FS_IDLE;
    endcase
    // region busy is bit 6 of the control image
    nxt_state.fetchBlk = nxt_state.blocked && !inNrww(fetchAddr[PC_W-1:0]);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================================
  // outputs
  assign flash              = state_ff.fl;
  assign bootMap            = state_ff.mp;
  assign selfProgControlReg = {1'b0, state_ff.busy, state_ff.ctrl[5:0]};
  assign readRegionBusyFlag = state_ff.busy;
  assign fetchBlocked       = state_ff.fetchBlk;
  assign readByteSel        = state_ff.byteSel;

  // ==========================================================================
  // checks
  property p_busy_hold;
    @(posedge ref_clk) disable iff (!rst_b)
      (state_ff.busy && !(state_ff.st == FS_ARMED && cpu.spmExec)) |=> state_ff.busy;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");

  // arming edge, then four cycles with no store instruction
  sequence s_arm;
    state_ff.st == FS_IDLE && nxt_state.st == FS_ARMED;
  endsequence

  sequence s_quiet4;
    (!cpu.spmExec)[*4];
  endsequence

  property p_window;
    @(posedge ref_clk) disable iff (!rst_b)
      s_arm ##1 s_quiet4 |=> state_ff.st == FS_IDLE;
  endproperty
  a_window: assert property (p_window) else $error("arming outlived window");

  // a reenable executing in this cycle may legally open the region
  property p_block;
    @(posedge ref_clk) disable iff (!rst_b)
      (state_ff.blocked && !(state_ff.st == FS_ARMED && cpu.spmExec) && fetchAddr < NONREADABLE_REGION_START)
        |=> fetchBlocked;
  endproperty
  a_block: assert property (p_block) else $error("readable region not blocked");

  property p_nonreadable_region_open;
    @(posedge ref_clk) disable iff (!rst_b)
      (fetchAddr >= NONREADABLE_REGION_START) |=> !fetchBlocked;
  endproperty
  a_nonreadable_region_open: assert property (p_nonreadable_region_open) else $error("nonreadable region blocked");

  property p_page;
    @(posedge ref_clk) disable iff (!rst_b)
      1'b1 |=> flash.pageSel == $past(cpu.zPtr[12:6]) && flash.bufWord == $past(cpu.zPtr[5:1]);
  endproperty
  a_page: assert property (p_page) else $error("pointer map wrong");

  property p_boot;
    @(posedge ref_clk) disable iff (!rst_b)
      ($past(rst_b) && $past(bootSize) == 2'h3) |-> bootMap.bootStart == 12'hf80 && bootMap.appEnd == 12'hf7f;
  endproperty
  a_boot: assert property (p_boot) else $error("boot start wrong");

  property p_time_min;
    @(posedge ref_clk) disable iff (!rst_b)
      (state_ff.st != FS_BUSY && nxt_state.st == FS_BUSY) |=> (state_ff.st == FS_BUSY)[*8];
  endproperty
  a_time_min: assert property (p_time_min) else $error("operation ended early");

  property p_busy_end;
    @(posedge ref_clk) disable iff (!rst_b)
      (state_ff.st == FS_BUSY && state_ff.timer == 17'h00001) |=> state_ff.st == FS_IDLE && !selfProgControlReg[0];
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("operation overran its count");

  property p_ee_lock;
    @(posedge ref_clk) disable iff (!rst_b)
      (state_ff.st == FS_IDLE && eepromWriteActiveFlag) |=> state_ff.st == FS_IDLE;
  endproperty
  a_ee_lock: assert property (p_ee_lock) else $error("armed during eeprom write");

  property p_byte;
    @(posedge ref_clk) disable iff (!rst_b)
      1'b1 |=> readByteSel == $past(cpu.zPtr[0]);
  endproperty
  a_byte: assert property (p_byte) else $error("byte select wrong");

endmodule : fspm_self_prog_map

// *** fspm_pkg.sv ***
// Purpose: shared constants and carriers for the flash self-programming map
// Assumes: 12-bit word addresses, 32-word pages, 20 MHz reference clock
// Notes:   figures named once here, except the PROG_CYC default in the top
package fspm_pkg;

  // ==========================================================================
  // geometry
  localparam int          PC_W          = 12;
  localparam int          PAGE_W        = 7;
  localparam int          WORD_W        = 5;
  localparam int          Z_W           = 16;
  localparam int          Z_WORD_LSB    = 1;
  localparam int          Z_WORD_MSB    = 5;
  localparam int          Z_PAGE_LSB    = 6;
  localparam int          Z_PAGE_MSB    = 12;
  localparam logic [11:0] NONREADABLE_REGION_START    = 12'hc00;
  localparam logic [11:0] FLASH_END     = 12'hfff;
  localparam logic [11:0] BOOT_START_11 = 12'hf80;
  localparam logic [11:0] BOOT_START_10 = 12'hf00;
  localparam logic [11:0] BOOT_START_01 = 12'he00;
  localparam logic [11:0] BOOT_START_00 = 12'hc00;
  localparam logic [10:0] BOOT_WORDS_11 = 11'h080;
  localparam logic [10:0] BOOT_WORDS_10 = 11'h100;
  localparam logic [10:0] BOOT_WORDS_01 = 11'h200;
  localparam logic [10:0] BOOT_WORDS_00 = 11'h400;

  // ==========================================================================
  // command codes and timing
  localparam logic [7:0]  CMD_FILL      = 8'h01;
  localparam logic [6:0]  CMD_WRITE_LO  = 7'h05;
  localparam logic [6:0]  CMD_ERASE_LO  = 7'h03;
  localparam logic [6:0]  CMD_LOCK_LO   = 7'h09;
  localparam logic [6:0]  CMD_REEN_LO   = 7'h11;
  localparam logic [2:0]  SPM_WINDOW    = 3'h4;
  localparam int          CLK_HZ        = 20000000;
  localparam int          PROG_MIN_US   = 3700;
  localparam int          PROG_MAX_US   = 4500;
  localparam int          PROG_MIN_CYC  = (PROG_MIN_US * (CLK_HZ / 1000000));
  localparam int          PROG_MAX_CYC  = (PROG_MAX_US * (CLK_HZ / 1000000));

  typedef enum logic [1:0] {FS_IDLE, FS_ARMED, FS_BUSY} fspm_state_e;

  typedef struct packed {
    logic [Z_W-1:0] zPtr;
    logic [7:0]     ctrlData;
    logic           ctrlWrite;
    logic           spmExec;
  } fspm_cpu_s;

  typedef struct packed {
    logic [PC_W-1:0] bootStart;
    logic [PC_W-1:0] appEnd;
    logic [10:0]     bootWords;
  } fspm_map_s;

  typedef struct packed {
    logic              bufWrite;
    logic [WORD_W-1:0] bufWord;
    logic              pageErase;
    logic              pageWrite;
    logic              lockWrite;
    logic [PAGE_W-1:0] pageSel;
    logic              bufClear;
  } fspm_flash_s;

  function automatic logic inNrww(input logic [PC_W-1:0] a);
    return a >= NONREADABLE_REGION_START;
  endfunction : inNrww

endpackage : fspm_pkg

// *** fspm_boot_map.sv ***
// Purpose: boot section sizing from the boot size fuse pair
// Assumes: fuses stable
// Notes:   pure decode, registered by the top
`timescale 1ns/100ps
module fspm_boot_map (
  input  wire logic [1:0]        bootSize,
  output fspm_pkg::fspm_map_s    map
);
  import fspm_pkg::*;

  // ==========================================================================
  // decode
  always_comb begin
    case (bootSize)
      2'h3: begin
        map.bootStart = BOOT_START_11;
        map.bootWords = BOOT_WORDS_11;
      end
      2'h2: begin
        map.bootStart = BOOT_START_10;
        map.bootWords = BOOT_WORDS_10;
      end
      2'h1: begin
        map.bootStart = BOOT_START_01;
        map.bootWords = BOOT_WORDS_01;
      end
      default: begin
        map.bootStart = BOOT_START_00;
        map.bootWords = BOOT_WORDS_00;
      end
    endcase
    map.appEnd = map.bootStart - 12'h001;
  end

endmodule : fspm_boot_map

// *** fspm_cpu_model.sv ***
// Purpose: cpu core model issuing timed self-programming sequences
// Assumes: drives on falling edges, polls status like boot code does
// Notes:   obey=0 skips the polls so that refusals can be provoked
`timescale 1ns/100ps
module fspm_cpu_model (
  input  wire logic           ref_clk,
  input  wire logic [7:0]     selfProgControlReg,
  input  wire logic           eepromWriteActiveFlag,
  output fspm_pkg::fspm_cpu_s cpu,
  output logic                hangSeen
);
  import fspm_pkg::*;
  initial begin
    cpu      = '0;
    hangSeen = 1'b0;
  end
  // ==========================================================================
  // sequences
  task automatic setZ(input logic [15:0] z);
    @(negedge ref_clk);
    cpu.zPtr = z;
  endtask : setZ
  // no interrupts modelled, so only a gap above four splits the timed pair
  task automatic doSpm(input logic [7:0] code, input logic [15:0] z, input int gap, input bit obey);
    int n;
    n = 0;
    while (obey && (selfProgControlReg[0] !== 1'b0 || eepromWriteActiveFlag) && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 200) hangSeen = 1'b1;
    @(negedge ref_clk);
    cpu.zPtr      = (code[6:0] == CMD_WRITE_LO) ? {z[15:6], 6'h00} : {z[15:1], 1'b0};
    cpu.ctrlData  = code;
    cpu.ctrlWrite = 1'b1;
    for (int i = 0; i < gap; i++) begin
      @(negedge ref_clk);
      cpu.ctrlWrite = 1'b0;
      cpu.spmExec   = (i == gap - 1);
    end
    @(negedge ref_clk);
    cpu.spmExec = 1'b0;
  endtask : doSpm
endmodule : fspm_cpu_model

// *** fspm_self_prog_map_tb.sv ***
// Purpose: self-checking bench for the self-programming map
// Assumes: PROG_CYC shortened so an operation lasts 20 cycles
// Notes:   expected map derived from boot end fixed at fff
`timescale 1ns/100ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module fspm_self_prog_map_tb;
  import fspm_pkg::*;
  localparam int PC = 20;
  logic        ref_clk, rst_b, eeBusy, hang, busy, blocked, byteSel;
  logic [1:0]  bootSize;
  logic [11:0] fetchAddr;
  logic [15:0] rnd, z;
  logic [7:0]  ctrl;
  fspm_cpu_s   cpu;
  fspm_flash_s flash;
  fspm_map_s   bootMap;
  int          error_cnt, cmp_count, n;
  fspm_self_prog_map #(.PROG_CYC(PC)) uut (.ref_clk(ref_clk), .rst_b(rst_b), .cpu(cpu),
    .eepromWriteActiveFlag(eeBusy), .bootSize(bootSize), .fetchAddr(fetchAddr), .flash(flash),
    .bootMap(bootMap), .selfProgControlReg(ctrl), .readRegionBusyFlag(busy), .fetchBlocked(blocked),
    .readByteSel(byteSel));
  fspm_cpu_model cpuModel (.ref_clk(ref_clk), .selfProgControlReg(ctrl), .eepromWriteActiveFlag(eeBusy),
    .cpu(cpu), .hangSeen(hang));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // ==========================================================================
  // helpers
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr
  function automatic fspm_map_s expMap(input logic [1:0] s);
    fspm_map_s m;
    m.bootWords = 11'h080 << (2'h3 - s);
    m.bootStart = 12'h000 - {1'b0, m.bootWords};
    m.appEnd    = m.bootStart - 12'h001;
    return m;
  endfunction : expMap
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  task automatic waitDone;
    n = 0;
    while (ctrl[0] !== 1'b0 && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 200) begin
      error_cnt++;
      end_of_test();
    end
  endtask : waitDone
  task automatic reen;
    cpuModel.doSpm({1'b0, CMD_REEN_LO}, 16'h0000, 2, 1'b1);
  endtask : reen
  // ==========================================================================
  // main sequence
  initial begin
    error_cnt = 0; cmp_count = 0; rst_b = 1'b0; eeBusy = 1'b0; bootSize = 2'h0; fetchAddr = 12'h000;
    rnd = 16'h0012;
    repeat (6) @(negedge ref_clk);
    rst_b = 1'b1;
    for (int s = 0; s < 4; s++) begin
      bootSize = 2'(s);
      repeat (2) @(negedge ref_clk);
      `CHK("bootMap", expMap(bootSize), bootMap)
    end
    $display("boot map test done");
    rnd = lfsr(rnd);
    cpuModel.doSpm({1'b0, CMD_ERASE_LO}, rnd ^ 16'he000, 2, 1'b1);
    `CHK("pageErase", 1'b1, flash.pageErase)
    `CHK("pageSel", rnd[12:6], flash.pageSel)
    fetchAddr = 12'hbff;
    repeat (2) @(negedge ref_clk);
    `CHK("blockedLow", 1'b1, blocked)
    fetchAddr = 12'hc00;
    repeat (2) @(negedge ref_clk);
    `CHK("blockedHigh", 1'b0, blocked)
    waitDone();
    `CHK("progTime", PC, n + 4)
    `CHK("busyHeld", 1'b1, busy)
    reen();
    `CHK("bufClear", 1'b1, flash.bufClear)
    for (int k = 0; k < 3 && busy !== 1'b0; k++) reen();
    `CHK("busyClear", 1'b0, busy)
    $display("erase test done");
    rnd = lfsr(rnd);
    for (int i = 0; i < 4; i++) begin
      z = rnd + 16'(2 * i);
      cpuModel.doSpm(CMD_FILL, z, i + 1, 1'b1);
      `CHK("bufWrite", 1'b1, flash.bufWrite)
      `CHK("bufWord", z[5:1], flash.bufWord)
    end
    cpuModel.doSpm(CMD_FILL, rnd, 5, 1'b1);
    `CHK("lateSpm", 1'b0, flash.bufWrite)
    eeBusy = 1'b1;
    cpuModel.doSpm(CMD_FILL, rnd, 2, 1'b0);
    `CHK("eeRefuse", 1'b0, flash.bufWrite)
    eeBusy = 1'b0;
    $display("fill test done");
    rnd = lfsr(rnd);
    cpuModel.doSpm({1'b1, CMD_WRITE_LO}, rnd, 2, 1'b1);
    `CHK("pageWrite", 1'b1, flash.pageWrite)
    `CHK("pageSelW", rnd[12:6], flash.pageSel)
    waitDone();
    reen();
    cpuModel.doSpm({1'b0, CMD_LOCK_LO}, 16'h0001, 2, 1'b1);
    `CHK("lockWrite", 1'b1, flash.lockWrite)
    `CHK("lockBusy", 1'b0, busy)
    waitDone();
    rnd = lfsr(rnd);
    cpuModel.setZ(rnd);
    repeat (2) @(negedge ref_clk);
    `CHK("byteSel", rnd[0], byteSel)
    `CHK("modelHang", 1'b0, hang)
    $display("write and lock test done");
    end_of_test();
  end
endmodule : fspm_self_prog_map_tb
